/* frame_seq_pkg.sv */
/*
 * Shared constants and types of the bus controller frame sequencer:
 * register offsets, field positions, start modes, table opcodes and timing.
 * Assumes a single 125 MHz clock and a plain register port.
 */
package frame_seq_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_IN_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SLOT_MS = 8'h04;
    localparam logic [7:0] OFS_MAJOR_CNT = 8'h08;
    localparam logic [7:0] OFS_START_ADDR = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_TBL_ADDR = 8'h14;
    localparam logic [7:0] OFS_TBL_DATA = 8'h18;

    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TABLE_BIT = 3;
    localparam int CTRL_LAUNCH_BIT = 4;
    localparam int CTRL_STOP_BIT = 5;
    // status fields
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_IMAGE_BIT = 1;
    localparam int STAT_TBLRUN_BIT = 2;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_PC_LSB = 16;
    localparam int STAT_REM_LSB = 24;

    // reset values
    localparam logic [15:0] SLOT_MS_RST = 16'h000A;
    localparam logic [15:0] MAJOR_CNT_RST = 16'h0000;

    // ----------------------------------------
    // instruction memory
    // ----------------------------------------
    localparam int PC_W = 6;
    localparam int TBL_DEPTH = 64;

    typedef enum logic [2:0] {
        start_mode_now = 3'h0,
        start_mode_trigger_in = 3'h1,
        start_mode_bus_handover = 3'h2,
        start_mode_pulse_framing = 3'h3,
        start_mode_prepare_image = 3'h4,
        start_mode_quick_launch = 3'h5,
        start_mode_program_table = 3'h6,
        start_mode_resume_after_stop = 3'h7
    } start_mode_t;

    typedef enum logic [3:0] {
        op_transfer = 4'h0,
        op_wait_slot = 4'h1,
        op_delay_ms = 4'h2,
        op_absolute_branch = 4'h3,
        op_decrement_branch_zero = 4'h4,
        op_halt = 4'h5,
        op_major_end = 4'h6
    } opcode_t;

    typedef struct packed {
        opcode_t op;
        logic [11:0] param;
    } entry_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

endpackage

/* frame_sequencer.sv */
/*
 * Bus controller frame sequencer: start modes, minor frame timing, autoframing,
 * pulse framing, major frame counting and instruction table walking.
 * Assumes synchronous inputs, a transfer engine answering i_xfer_done, and
 * single-cycle register strobes with read data one cycle later.
 */
// What this block does
// [RULE_01] each minor frame starts timing, runs entries back to back, idles to slot end
// [RULE_02] minor frame time register holds milliseconds
// [RULE_03] immediate mode runs as soon as launch is accepted
// [RULE_04] trigger mode waits for a trigger edge before running
// [RULE_05] handover mode runs when bus control is handed over
// [RULE_06] pulse mode: trigger pulses mark minor frame boundaries, not the timer
// [RULE_07] all other modes restart minor frames automatically
// [RULE_08] pulse mode starts a minor frame on each trigger rising edge
// [RULE_09] pulse mode: a leading wait entry runs right after the edge
// [RULE_10] prepare mode readies the image without sending; quick mode launches it
// [RULE_11] table mode fetches and executes entries from the instruction table
// [RULE_12] resume continues a halted table, only after a table launch
// [RULE_13] table framing accepts only table and resume modes; others only standard
// [RULE_14] count zero repeats forever in standard framing; nonzero sends that many
// [RULE_15] after the requested major frames the controller halts
// [RULE_16] table repeats through a final branch back to the start or through a major end entry, which restarts it at entry 0
// [RULE_17] decrement branch entry uses the major frame count to end cycling
// [RULE_18] decrement branch entry counts down and branches when zero
// [RULE_19] zero start address begins the table at its first entry
// [RULE_20] nonzero start address begins at that labelled entry
// [RULE_21] trigger is synchronised with a single-cycle rising edge detect
`timescale 1ns/10ps
module frame_sequencer #(
    parameter int MS_CYCLES = frame_seq_pkg::CYCLES_PER_MS
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire frame_seq_pkg::reg_req_t i_req,
    output logic [31:0] o_rdata,
    input wire logic i_trig,
    input wire logic i_bus_handover,
    input wire logic i_xfer_done,
    output logic o_xfer_req,
    output logic [11:0] o_xfer_id,
    output logic o_running,
    output logic o_halted
);
    import frame_seq_pkg::*;
    typedef enum logic [6:0] {
        st_idle = 7'b000_0001,
        st_armed = 7'b000_0010,
        st_fetch = 7'b000_0100,
        st_xfer = 7'b000_1000,
        st_slot = 7'b001_0000,
        st_delay = 7'b010_0000,
        st_halted = 7'b100_0000
    } state_t;
    function automatic logic is_table_mode(input start_mode_t m);
        is_table_mode = (m == start_mode_program_table) || (m == start_mode_resume_after_stop);
    endfunction
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    state_t state_r, state_nxt;
    entry_t table_mem [TBL_DEPTH];
    entry_t cur;
    start_mode_t mode_r, run_mode_r, wmode;
    logic [15:0] slot_ms_r, major_cnt_r, remaining_r, slot_elapsed_r;
    logic [PC_W-1:0] start_addr_r, tbl_addr_r, pc_r, pc_nxt;
    logic [16:0] ms_div_r;
    logic [11:0] delay_r;
    logic [31:0] rdata_nxt;
    logic table_frm_r, err_r, image_r, tbl_run_r;
    logic trig_s1_r, trig_s2_r, trig_s3_r, trig_edge;
    logic ms_tick, slot_over, frame_start, rem_load, rem_dec;
    logic wr_ctrl, launch, stop, accept, bad_mode, start_run, err_set, err_clr;
    assign cur = table_mem[pc_r];
    assign wmode = start_mode_t'(i_req.wdata[CTRL_MODE_LSB +: 3]);
    // ----------------------------------------
    // trigger synchroniser
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end else begin
            trig_s1_r <= i_trig; // RULE_21
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end
    assign trig_edge = trig_s2_r & ~trig_s3_r; // RULE_21
    // ----------------------------------------
    // launch decode
    // ----------------------------------------
    assign wr_ctrl = i_req.we && (i_req.addr == OFS_CTRL);
    assign launch = wr_ctrl && i_req.wdata[CTRL_LAUNCH_BIT];
    assign stop = wr_ctrl && i_req.wdata[CTRL_STOP_BIT];
    always_comb begin
        bad_mode = 1'b0;
        if (i_req.wdata[CTRL_TABLE_BIT] != is_table_mode(wmode)) begin
            bad_mode = 1'b1; // RULE_13
        end else if (wmode == start_mode_quick_launch && !image_r) begin
            bad_mode = 1'b1; // RULE_10
        end else if (wmode == start_mode_resume_after_stop
                     && !(tbl_run_r && state_r == st_halted)) begin
            bad_mode = 1'b1; // RULE_12
        end else if (wmode != start_mode_resume_after_stop
                     && state_r != st_idle && state_r != st_halted) begin
            bad_mode = 1'b1;
        end
    end
    assign accept = launch && !stop && !bad_mode;
    assign start_run = accept && wmode != start_mode_prepare_image; // RULE_10
    assign err_set = launch && !stop && bad_mode;
    assign err_clr = i_req.we && (i_req.addr == OFS_STATUS) && i_req.wdata[STAT_ERR_BIT];
    // ----------------------------------------
    // millisecond divider and slot timer
    // ----------------------------------------
    assign ms_tick = (ms_div_r == 17'(MS_CYCLES - 1));
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ms_div_r <= 17'h0_0000;
        end else if (frame_start || ms_tick) begin
            ms_div_r <= 17'h0_0000;
        end else begin
            ms_div_r <= ms_div_r + 17'h0_0001;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            slot_elapsed_r <= 16'h0000;
        end else if (frame_start) begin
            slot_elapsed_r <= 16'h0000; // RULE_01
        end else if (ms_tick && !slot_over) begin
            slot_elapsed_r <= slot_elapsed_r + 16'h0001; // RULE_02
        end
    end
    assign slot_over = (slot_elapsed_r >= slot_ms_r);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            delay_r <= 12'h000;
        end else if (state_r == st_fetch && cur.op == op_delay_ms) begin
            delay_r <= cur.param;
        end else if (state_r == st_delay && ms_tick && delay_r != 12'h000) begin
            delay_r <= delay_r - 12'h001;
        end
    end

    // ----------------------------------------
    // sequencer state machine
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        frame_start = 1'b0;
        rem_load = 1'b0;
        rem_dec = 1'b0;
        case (state_r)
            st_idle, st_halted: begin
                if (start_run) begin
                    rem_load = (wmode != start_mode_resume_after_stop);
                    if (wmode == start_mode_resume_after_stop) begin
                        pc_nxt = pc_r + PC_W'(1); // RULE_12
                        state_nxt = st_fetch;
                        frame_start = 1'b1;
                    end else if (wmode == start_mode_program_table) begin
                        pc_nxt = start_addr_r; // RULE_19 RULE_20
                        state_nxt = st_fetch; // RULE_11
                        frame_start = 1'b1;
                    end else if (wmode == start_mode_now
                                 || wmode == start_mode_quick_launch) begin
                        pc_nxt = '0;
                        state_nxt = st_fetch; // RULE_03 RULE_10
                        frame_start = 1'b1;
                    end else begin
                        pc_nxt = '0;
                        state_nxt = st_armed; // RULE_04 RULE_05
                    end
                end
            end
            st_armed: begin
                if ((run_mode_r == start_mode_bus_handover && i_bus_handover) // RULE_05
                    || (run_mode_r != start_mode_bus_handover && trig_edge)) begin
                    state_nxt = st_fetch; // RULE_04 RULE_08
                    frame_start = 1'b1;
                end
            end
            st_fetch: begin
                pc_nxt = pc_r + PC_W'(1);
                case (cur.op)
                    op_transfer: state_nxt = st_xfer; // RULE_01
                    op_wait_slot: state_nxt = st_slot;
                    op_delay_ms: state_nxt = st_delay; // RULE_09
                    op_absolute_branch: pc_nxt = cur.param[PC_W-1:0]; // RULE_16
                    op_decrement_branch_zero: begin
                        rem_dec = (remaining_r != 16'h0000); // RULE_17
                        if (remaining_r <= 16'h0001) begin
                            pc_nxt = cur.param[PC_W-1:0]; // RULE_18
                        end
                    end
                    op_halt: begin
                        pc_nxt = pc_r;
                        state_nxt = st_halted;
                    end
                    op_major_end: begin
                        pc_nxt = '0; // RULE_14
                        if (major_cnt_r != 16'h0000) begin
                            rem_dec = 1'b1;
                            if (remaining_r <= 16'h0001) begin
                                pc_nxt = pc_r;
                                state_nxt = st_halted; // RULE_15
                            end
                        end
                    end
                    default: state_nxt = st_halted;
                endcase
            end
            st_xfer: begin
                if (i_xfer_done) begin
                    state_nxt = st_fetch;
                end
            end
            st_delay: begin
                if (delay_r == 12'h000) begin
                    state_nxt = st_fetch;
                end
            end
            st_slot: begin
                if (run_mode_r == start_mode_pulse_framing) begin
                    if (trig_edge) begin
                        state_nxt = st_fetch; // RULE_06 RULE_08
                        frame_start = 1'b1;
                    end
                end else if (slot_over) begin
                    state_nxt = st_fetch; // RULE_01 RULE_07
                    frame_start = 1'b1;
                end
            end
            default: state_nxt = st_idle;
        endcase
        if (stop) begin
            state_nxt = st_idle;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= st_idle;
            pc_r <= '0;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
        end
    end

    // ----------------------------------------
    // run context and major frame count
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_mode_r <= start_mode_now;
            tbl_run_r <= 1'b0;
        end else if (stop) begin
            tbl_run_r <= 1'b0;
        end else if (start_run && wmode != start_mode_resume_after_stop) begin
            run_mode_r <= wmode;
            tbl_run_r <= (wmode == start_mode_program_table); // RULE_12
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            image_r <= 1'b0;
        end else if (accept && wmode == start_mode_prepare_image) begin
            image_r <= 1'b1; // RULE_10
        end else if (i_req.we && i_req.addr == OFS_TBL_DATA) begin
            image_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            remaining_r <= 16'h0000;
        end else if (rem_load) begin
            remaining_r <= major_cnt_r; // RULE_14
        end else if (rem_dec) begin
            remaining_r <= remaining_r - 16'h0001; // RULE_15 RULE_17
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            err_r <= 1'b0;
        end else if (err_set) begin
            err_r <= 1'b1;
        end else if (err_clr) begin
            err_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // transfer request
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_xfer_req <= 1'b0;
            o_xfer_id <= 12'h000;
        end else begin
            o_xfer_req <= (state_r == st_fetch) && (cur.op == op_transfer) && !stop;
            if (state_r == st_fetch && cur.op == op_transfer) begin
                o_xfer_id <= cur.param;
            end
        end
    end

    assign o_running = (state_r != st_idle) && (state_r != st_halted);
    assign o_halted = (state_r == st_halted);

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_r <= start_mode_now;
            table_frm_r <= 1'b0;
            slot_ms_r <= SLOT_MS_RST;
            major_cnt_r <= MAJOR_CNT_RST;
            start_addr_r <= '0;
            tbl_addr_r <= '0;
        end else if (i_req.we) begin
            case (i_req.addr)
                OFS_CTRL: begin
                    mode_r <= wmode;
                    table_frm_r <= i_req.wdata[CTRL_TABLE_BIT];
                end
                OFS_SLOT_MS: slot_ms_r <= i_req.wdata[15:0]; // RULE_02
                OFS_MAJOR_CNT: major_cnt_r <= i_req.wdata[15:0];
                OFS_START_ADDR: start_addr_r <= i_req.wdata[PC_W-1:0];
                OFS_TBL_ADDR: tbl_addr_r <= i_req.wdata[PC_W-1:0];
                OFS_TBL_DATA: tbl_addr_r <= tbl_addr_r + PC_W'(1);
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_req.we && i_req.addr == OFS_TBL_DATA) begin
            table_mem[tbl_addr_r] <= entry_t'(i_req.wdata[15:0]);
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (i_req.addr)
            OFS_CTRL: begin
                rdata_nxt[CTRL_MODE_LSB +: 3] = mode_r;
                rdata_nxt[CTRL_TABLE_BIT] = table_frm_r;
            end
            OFS_SLOT_MS: rdata_nxt[15:0] = slot_ms_r;
            OFS_MAJOR_CNT: rdata_nxt[15:0] = major_cnt_r;
            OFS_START_ADDR: rdata_nxt[PC_W-1:0] = start_addr_r;
            OFS_STATUS: begin
                rdata_nxt[STAT_ERR_BIT] = err_r;
                rdata_nxt[STAT_IMAGE_BIT] = image_r;
                rdata_nxt[STAT_TBLRUN_BIT] = tbl_run_r;
                rdata_nxt[STAT_STATE_LSB +: 7] = state_r;
                rdata_nxt[STAT_PC_LSB +: PC_W] = pc_r;
                rdata_nxt[STAT_REM_LSB +: 8] = remaining_r[7:0];
            end
            OFS_TBL_ADDR: rdata_nxt[PC_W-1:0] = tbl_addr_r;
            OFS_TBL_DATA: rdata_nxt[15:0] = table_mem[tbl_addr_r];
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_req.re) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end
endmodule

/* fs_props.sv */
/*
 * port checker of the frame sequencer.
 * assumes one clock domain and binding from tb_top.
 */
`timescale 1ns/10ps
module fs_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire frame_seq_pkg::reg_req_t i_req,
    input wire logic [31:0] o_rdata,
    input wire logic i_trig,
    input wire logic i_bus_handover,
    input wire logic i_xfer_done,
    input wire logic o_xfer_req,
    input wire logic [11:0] o_xfer_id,
    input wire logic o_running,
    input wire logic o_halted
);
    import frame_seq_pkg::*;
    logic pend_r;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // ----------------------------------------
    // outstanding transfer tracker
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            pend_r <= 1'b0;
        else if (o_xfer_req)
            pend_r <= 1'b1;
        else if (i_xfer_done || !o_running)
            pend_r <= 1'b0;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_req_pulse;
        o_xfer_req |=> !o_xfer_req;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("long xfer request");
    property p_one_pend;
        o_xfer_req |-> !pend_r;
    endproperty
    a_one_pend: assert property (p_one_pend) else $error("second xfer outstanding");
    property p_req_running;
        o_xfer_req |-> o_running && !o_halted;
    endproperty
    a_req_running: assert property (p_req_running) else $error("xfer while inactive");
    property p_halt_excl;
        o_halted |-> !o_running;
    endproperty
    a_halt_excl: assert property (p_halt_excl) else $error("halted and running");
    property p_id_stable;
        $changed(o_xfer_id) |-> o_xfer_req;
    endproperty
    a_id_stable: assert property (p_id_stable) else $error("xfer id moved");
    property p_idle_stays;
        !o_running && !i_req.we |=> !o_running;
    endproperty
    a_idle_stays: assert property (p_idle_stays) else $error("started unasked");
    property p_launch_now;
        i_req.we && i_req.addr == OFS_CTRL && i_req.wdata[5:0] == 6'h10 && !o_running
            |=> o_running;
    endproperty
    a_launch_now: assert property (p_launch_now) else $error("launch not taken");
    property p_rdata_zero;
        !i_req.re |=> o_rdata == 32'h0000_0000;
    endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside slot");
endmodule

/* rt_model.sv */
/*
 * transfer engine and terminal stand-in.
 * answers each request with one done pulse, fast or slow.
 */
`timescale 1ns/10ps
module rt_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_slow,
    output logic o_done
);
    logic busy_r;
    logic [3:0] cnt_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_req) begin
                busy_r <= 1'b1;
                cnt_r <= i_slow ? 4'h6 : 4'h1;
            end else if (busy_r && cnt_r == 4'h0) begin
                busy_r <= 1'b0;
                o_done <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule

/* tb_top.sv */
/*
 * self-checking bench of the frame sequencer.
 * assumes rt_model as transfer engine and a 10-cycle millisecond.
 */
`timescale 1ns/10ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t %s", $time, m); end end
module tb_top;
    import frame_seq_pkg::*;
    logic i_clk, i_rst, i_trig, i_bus_handover, slow, xfer_done;
    reg_req_t req;
    logic [31:0] o_rdata, v;
    logic o_xfer_req, o_running, o_halted;
    logic [11:0] o_xfer_id;
    logic [11:0] ids[$];
    int ts[$];
    int bad_count, checked, cyc;
    logic [15:0] tbl[14] = '{16'h0001, 16'h0002, 16'h1000, 16'h2001, 16'h0003, 16'h1000,
        16'h6000, 16'h0000, 16'h0005, 16'h400B, 16'h3008, 16'h5000, 16'h0006, 16'h5000};
    frame_sequencer #(.MS_CYCLES(10)) frame_sequencer_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_req(req), .o_rdata(o_rdata), .i_trig(i_trig), .i_bus_handover(i_bus_handover),
        .i_xfer_done(xfer_done), .o_xfer_req(o_xfer_req), .o_xfer_id(o_xfer_id),
        .o_running(o_running), .o_halted(o_halted));
    rt_model rt_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(o_xfer_req), .i_slow(slow),
        .o_done(xfer_done));
    // ----------------------------------------
    // clock, log and timeout
    // ----------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (o_xfer_req === 1'b1) begin
            ids.push_back(o_xfer_id);
            ts.push_back(cyc);
        end
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic summarize;
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        req.we <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge i_clk);
        req.we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        req.re <= 1'b1;
        req.addr <= a;
        @(posedge i_clk);
        req.re <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic launch(input logic [3:0] m);
        wr(OFS_CTRL, 32'h0000_0010 | {28'h000_0000, m});
    endtask
    task automatic err_chk;
        rd(OFS_STATUS);
        `CHK(v[STAT_ERR_BIT], 1'b1, "bad launch accepted")
        wr(OFS_STATUS, 32'h0000_0001);
    endtask
    task automatic pulse(input bit h);
        @(posedge i_clk);
        if (h)
            i_bus_handover <= 1'b1;
        else
            i_trig <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_bus_handover <= 1'b0;
        i_trig <= 1'b0;
    endtask
    task automatic wait_halt;
        for (int n = 0; n < 3000; n++) begin
            @(posedge i_clk);
            #1;
            if (o_halted === 1'b1)
                break;
        end
        `CHK(o_halted, 1'b1, "no halt")
    endtask
    task automatic chk_ids(input int n, input logic [71:0] e);
        `CHK(ids.size(), n, "transfer count")
        for (int i = 0; i < n && i < ids.size(); i++)
            `CHK(ids[i], e[12*(n-1-i)+:12], "transfer id")
        ids.delete();
        ts.delete();
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        i_rst = 1'b1;
        req = '0;
        i_trig = 1'b0;
        i_bus_handover = 1'b0;
        slow = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(OFS_SLOT_MS);
        `CHK(v, {16'h0000, SLOT_MS_RST}, "slot reset value")
        rd(OFS_MAJOR_CNT);
        `CHK(v, 32'h0000_0000, "count reset value")
        rd(OFS_STATUS);
        `CHK(v[14:8], 7'h01, "not idle")
        rd(8'h1C);
        `CHK(v, 32'h0000_0000, "unmapped read")
        launch(4'hF);
        err_chk();
        wr(OFS_TBL_ADDR, 32'h0000_0000);
        foreach (tbl[i])
            wr(OFS_TBL_DATA, {16'h0000, tbl[i]});
        wr(OFS_TBL_ADDR, 32'h0000_0009);
        rd(OFS_TBL_DATA);
        `CHK(v[15:0], 16'h400B, "table readback")
        wr(OFS_SLOT_MS, 32'h0000_0002);
        wr(OFS_MAJOR_CNT, 32'h0000_0002);
        launch(4'h0);
        wait_halt();
        `CHK((ts[2] - ts[0]) inside {[30:36]}, 1'b1, "minor slot time")
        `CHK((ts[3] - ts[0]) inside {[40:56]}, 1'b1, "major time")
        chk_ids(6, {12'h001, 12'h002, 12'h003, 12'h001, 12'h002, 12'h003});
        launch(4'h8);
        err_chk();
        launch(4'h6);
        err_chk();
        wr(OFS_MAJOR_CNT, 32'h0000_0001);
        for (int m = 1; m < 3; m++) begin
            launch(m[3:0]);
            repeat (30) @(posedge i_clk);
            `CHK(ids.size(), 0, "early start")
            pulse(m == 2);
            wait_halt();
            chk_ids(3, {12'h001, 12'h002, 12'h003});
        end
        launch(4'h3);
        pulse(1'b0);
        repeat (50) @(posedge i_clk);
        `CHK(ids.size(), 2, "timer framed a pulse frame")
        pulse(1'b0);
        repeat (6) @(posedge i_clk);
        `CHK(ids.size(), 2, "leading delay skipped")
        repeat (14) @(posedge i_clk);
        `CHK(ids.size(), 3, "no frame on edge")
        pulse(1'b0);
        wait_halt();
        chk_ids(3, {12'h001, 12'h002, 12'h003});
        launch(4'h5);
        err_chk();
        launch(4'h4);
        repeat (30) @(posedge i_clk);
        rd(OFS_STATUS);
        `CHK(v[STAT_IMAGE_BIT], 1'b1, "image not ready")
        `CHK(ids.size(), 0, "prepare sent data")
        launch(4'h5);
        wait_halt();
        chk_ids(3, {12'h001, 12'h002, 12'h003});
        wr(OFS_MAJOR_CNT, 32'h0000_0000);
        launch(4'h0);
        repeat (150) @(posedge i_clk);
        `CHK(ids.size() >= 6, 1'b1, "not repeating")
        `CHK(o_halted, 1'b0, "halted in cyclic run")
        wr(OFS_CTRL, 32'h0000_0020);
        @(posedge i_clk);
        #1;
        `CHK(o_running, 1'b0, "stop ignored")
        ids.delete();
        ts.delete();
        slow <= 1'b1;
        wr(OFS_MAJOR_CNT, 32'h0000_0002);
        wr(OFS_START_ADDR, 32'h0000_0008);
        launch(4'hE);
        wait_halt();
        chk_ids(2, {12'h005, 12'h005});
        launch(4'hF);
        wait_halt();
        chk_ids(1, {12'h006});
        wr(OFS_START_ADDR, 32'h0000_0000);
        launch(4'hE);
        wait_halt();
        chk_ids(6, {12'h001, 12'h002, 12'h003, 12'h001, 12'h002, 12'h003});
        summarize();
    end
endmodule
bind frame_sequencer fs_props fs_props_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
    .o_rdata(o_rdata), .i_trig(i_trig), .i_bus_handover(i_bus_handover),
    .i_xfer_done(i_xfer_done), .o_xfer_req(o_xfer_req), .o_xfer_id(o_xfer_id),
    .o_running(o_running), .o_halted(o_halted));
